// [hdl/fdma_pkg.sv]
// Constants and carrier types of the floppy DMA function sequencer.
package fdma_pkg;
   localparam int CS_GO = 0;
   localparam int CS_FN = 1;
   localparam int CS_UNIT = 4;
   localparam int CS_DONE = 5;
   localparam int CS_IE = 6;
   localparam int CS_TR = 7;
   localparam int CS_DEN = 8;
   localparam int CS_ID = 11;
   localparam int CS_EXT = 12;
   localparam int CS_INIT = 14;
   localparam int CS_ERR = 15;
   localparam int ES_INITD = 1;
   localparam int ES_DENERR = 4;
   localparam int ES_DEN = 5;
   localparam int ES_DD = 6;
   localparam int ES_RDY = 7;
   localparam int ES_UNIT = 8;
   localparam int ES_WCO = 10;
   localparam int ES_NXM = 11;
   localparam logic [2:0] FN_FILL = 3'h0;
   localparam logic [2:0] FN_EMPTY = 3'h1;
   localparam logic [2:0] FN_WRITE = 3'h2;
   localparam logic [2:0] FN_STATUS = 3'h5;
   localparam logic [2:0] FN_WRDEL = 3'h6;
   localparam logic [15:0] WC_DOUBLE = 16'h0080;
   localparam logic [15:0] WC_SINGLE = 16'h0040;
   localparam logic [15:0] BA_STEP = 16'h0002;
   localparam logic [1:0] REVS_MAX = 2'h2;
   localparam int CLK_MHZ = 10;
   localparam int NXM_TIMEOUT_NS = 10000;
   localparam int NXM_CYC = NXM_TIMEOUT_NS * CLK_MHZ / 1000;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] ES_RESET = 16'h0000;
   typedef struct packed {
      logic        sel;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } reg_req_s;
endpackage

// [hdl/fdma_seq.sv]
// Command/data register sequencer with DMA and sector write for two drives.
`timescale 1ns/1ps
module fdma_seq (
   // Clock and reset.
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   // Register port: sel 0 is command/status, 1 is data path.
   input  wire fdma_pkg::reg_req_s reg_req_in,
   output logic [15:0]            reg_rdata_out,
   output logic                   irq_out,
   // DMA master.
   output logic                   dma_req_out,
   output logic                   dma_write_out,
   output logic [17:0]            dma_addr_out,
   output logic [15:0]            dma_wdata_out,
   input  wire logic [15:0]       dma_rdata_in,
   input  wire logic              dma_ack_in,
   // Drive side pins.
   input  wire logic [1:0]        drv_den_in,
   input  wire logic [1:0]        drv_ready_in,
   input  wire logic              sec_found_in,
   input  wire logic              del_mark_in,
   input  wire logic              index_in,
   input  wire logic              word_req_in,
   output logic                   seek_out,
   output logic [7:0]             track_out,
   output logic [7:0]             sector_out,
   output logic                   unit_out,
   output logic                   wr_word_out,
   output logic [15:0]            wr_data_out,
   output logic                   wr_del_out
);
   import fdma_pkg::*;

   typedef enum {S_IDLE, S_WC, S_BA, S_DMA, S_ZERO, S_SA, S_TA, S_SRCH, S_WR,
                 S_CRC, S_STAT, S_FIN} state_e;

   function automatic logic [15:0] crc_word(input logic [15:0] c,
                                            input logic [15:0] w);
      logic [15:0] r;
      r = c;
      for (int i = 15; i >= 0; i--) begin
         r = {r[14:0], 1'b0} ^ ((r[15] ^ w[i]) ? CRC_POLY : 16'h0000);
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic [1:0]  rst_q;
   logic        rst_n;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) rst_q <= 2'h0;
      else rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   // Pins are filtered: a level counts once the second and third stages agree.
   logic [7:0]  pin_raw;
   logic [7:0]  s1_q;
   logic [7:0]  s2_q;
   logic [7:0]  s3_q;
   logic [7:0]  pin_q;
   logic [7:0]  pin_old_q;
   assign pin_raw = {word_req_in, index_in, del_mark_in, sec_found_in,
                     drv_ready_in, drv_den_in};
   for (genvar g = 0; g < 8; g++) begin : g_sync
      always_ff @(posedge clk_in or negedge rst_n) begin
         if (!rst_n) begin
            s1_q[g] <= 1'b0;
            s2_q[g] <= 1'b0;
            s3_q[g] <= 1'b0;
            pin_q[g] <= 1'b0;
            pin_old_q[g] <= 1'b0;
         end else begin
            s1_q[g] <= pin_raw[g];
            s2_q[g] <= s1_q[g];
            s3_q[g] <= s2_q[g];
            if (s2_q[g] == s3_q[g]) pin_q[g] <= s3_q[g];
            pin_old_q[g] <= pin_q[g];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   state_e      st_q;
   logic [2:0]  fn_q;
   logic        unit_q, done_q, ie_q, tr_q, den_q, err_q, irq_q;
   logic [1:0]  ext_q;
   logic [15:0] es_q, db_q, wc_q, ba_q, crc_q, rdata_q, dwd_q;
   logic [7:0]  idx_q;
   logic [1:0]  rev_q;
   logic [7:0]  nxm_q;
   logic        req_q, gap_q, seek_q, wrw_q;
   logic [7:0]  trk_q, sec_q;
   logic [15:0] buf_q [128];

   logic        cs_wr, db_wr, db_rd, start, db_take, dma_done;
   logic        found_r, index_r, wreq_r, sel_den, sel_rdy, is_fill;
   logic [15:0] lim, cs_word, es_word;
   logic [7:0]  lim8;

   assign cs_wr = reg_req_in.wr && !reg_req_in.sel;
   assign db_wr = reg_req_in.wr && reg_req_in.sel;
   assign db_rd = reg_req_in.rd && reg_req_in.sel;
   assign start = cs_wr && reg_req_in.wdata[CS_GO] && done_q;
   assign db_take = db_wr && tr_q;
   assign lim = den_q ? WC_DOUBLE : WC_SINGLE;
   assign lim8 = lim[7:0];
   assign is_fill = (fn_q == FN_FILL);
   assign found_r = pin_q[4] && !pin_old_q[4];
   assign index_r = pin_q[6] && !pin_old_q[6];
   assign wreq_r = pin_q[7] && !pin_old_q[7];
   assign sel_den = unit_q ? pin_q[1] : pin_q[0];
   assign sel_rdy = unit_q ? pin_q[3] : pin_q[2];
   assign dma_done = dma_ack_in && req_q;
   assign es_word = {es_q[15:9], unit_q, es_q[7:0]};
   assign cs_word = {err_q, 1'b0, 2'h0, 1'b1, 2'h0, done_q ? den_q : 1'b0, tr_q, ie_q,
                     done_q, done_q ? unit_q : 1'b0, 4'h0};

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= S_IDLE;
         fn_q <= FN_FILL;
         {unit_q, ie_q, tr_q, den_q, err_q, irq_q} <= 6'h00;
         done_q <= 1'b1;
         ext_q <= 2'h0;
         es_q <= ES_RESET;
         {db_q, wc_q, ba_q, crc_q, dwd_q} <= {5{16'h0000}};
         {idx_q, nxm_q, trk_q, sec_q} <= 32'h0000_0000;
         rev_q <= 2'h0;
         {req_q, gap_q, seek_q, wrw_q} <= 4'h0;
      end else begin
         seek_q <= 1'b0;
         wrw_q <= 1'b0;
         if (cs_wr) irq_q <= 1'b0;
         if (cs_wr && reg_req_in.wdata[CS_INIT]) begin
            st_q <= S_FIN;
            es_q <= ES_RESET;
            es_q[ES_INITD] <= 1'b1;
            {tr_q, err_q, req_q, ie_q} <= 4'h0;
            done_q <= 1'b0;
         end else if (!done_q && !tr_q && st_q == S_IDLE) begin
            done_q <= 1'b1;
         end else if (start) begin
            fn_q <= reg_req_in.wdata[CS_FN +: 3];
            unit_q <= reg_req_in.wdata[CS_UNIT];
            ie_q <= reg_req_in.wdata[CS_IE];
            den_q <= reg_req_in.wdata[CS_DEN];
            ext_q <= reg_req_in.wdata[CS_EXT +: 2];
            done_q <= 1'b0;
            err_q <= 1'b0;
            case (reg_req_in.wdata[CS_FN +: 3])
               FN_FILL, FN_EMPTY: begin
                  tr_q <= 1'b1;
                  st_q <= S_WC;
               end
               FN_WRITE, FN_WRDEL: begin
                  es_q <= ES_RESET;
                  tr_q <= 1'b0;
                  st_q <= S_SA;
               end
               FN_STATUS: st_q <= S_STAT;
               default: st_q <= S_FIN;
            endcase
         end else begin
            case (st_q)
               S_WC: if (db_take) begin
                  tr_q <= 1'b0;
                  wc_q <= reg_req_in.wdata;
                  if (reg_req_in.wdata > lim) begin
                     es_q[ES_WCO] <= 1'b1;
                     err_q <= 1'b1;
                     st_q <= S_FIN;
                  end else begin
                     st_q <= S_BA;
                  end
               end
               S_BA: if (!tr_q) begin
                  tr_q <= 1'b1;
               end else if (db_take) begin
                  tr_q <= 1'b0;
                  ba_q <= reg_req_in.wdata;
                  idx_q <= 8'h00;
                  gap_q <= 1'b1;
                  st_q <= S_DMA;
               end
               S_DMA: if (wc_q == 16'h0000) begin
                  st_q <= is_fill ? S_ZERO : S_FIN;
               end else if (gap_q) begin
                  gap_q <= 1'b0;
                  req_q <= 1'b1;
                  nxm_q <= 8'h00;
               end else if (dma_done) begin
                  if (is_fill) buf_q[idx_q[6:0]] <= dma_rdata_in;
                  req_q <= 1'b0;
                  gap_q <= 1'b1;
                  idx_q <= idx_q + 8'h01;
                  ba_q <= ba_q + BA_STEP;
                  wc_q <= wc_q - 16'h0001;
               end else if (nxm_q == 8'(NXM_CYC - 1)) begin
                  es_q[ES_NXM] <= 1'b1;
                  err_q <= 1'b1;
                  req_q <= 1'b0;
                  st_q <= S_FIN;
               end else begin
                  nxm_q <= nxm_q + 8'h01;
               end
               S_ZERO: if (idx_q == lim8) begin
                  st_q <= S_FIN;
               end else begin
                  buf_q[idx_q[6:0]] <= 16'h0000;
                  idx_q <= idx_q + 8'h01;
               end
               S_SA, S_TA: if (!tr_q) begin
                  tr_q <= 1'b1;
               end else if (db_take) begin
                  tr_q <= 1'b0;
                  if (st_q == S_SA) begin
                     sec_q <= reg_req_in.wdata[7:0];
                     st_q <= S_TA;
                  end else begin
                     trk_q <= reg_req_in.wdata[7:0];
                     seek_q <= 1'b1;
                     rev_q <= 2'h0;
                     st_q <= S_SRCH;
                  end
               end
               S_SRCH: if (found_r) begin
                  es_q[ES_DEN] <= sel_den;
                  es_q[ES_DD] <= pin_q[5];
                  if (sel_den != den_q) begin
                     es_q[ES_DENERR] <= 1'b1;
                     err_q <= 1'b1;
                     st_q <= S_FIN;
                  end else begin
                     idx_q <= 8'h00;
                     crc_q <= CRC_INIT;
                     st_q <= S_WR;
                  end
               end else if (index_r) begin
                  rev_q <= rev_q + 2'h1;
                  if (rev_q + 2'h1 == REVS_MAX) begin
                     err_q <= 1'b1;
                     st_q <= S_FIN;
                  end
               end
               S_WR: if (wreq_r) begin
                  dwd_q <= buf_q[idx_q[6:0]];
                  wrw_q <= 1'b1;
                  crc_q <= crc_word(crc_q, buf_q[idx_q[6:0]]);
                  idx_q <= idx_q + 8'h01;
                  if (idx_q + 8'h01 == lim8) st_q <= S_CRC;
               end
               S_CRC: if (wreq_r) begin
                  dwd_q <= crc_q;
                  wrw_q <= 1'b1;
                  st_q <= S_FIN;
               end
               S_STAT: begin
                  es_q[ES_RDY] <= sel_rdy;
                  es_q[ES_DEN] <= sel_den;
                  st_q <= S_FIN;
               end
               S_FIN: begin
                  done_q <= 1'b1;
                  irq_q <= ie_q;
                  db_q <= es_word;
                  st_q <= S_IDLE;
               end
               default: begin
                  if (db_wr && done_q) db_q <= reg_req_in.wdata;
                  st_q <= S_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) rdata_q <= 16'h0000;
      else if (reg_req_in.rd && !reg_req_in.sel) rdata_q <= cs_word;
      else if (db_rd && st_q != S_DMA) rdata_q <= db_q;
   end

   logic [17:0] addr_q;
   logic [15:0] dmaw_q;
   logic        dwr_q;
   logic        wdel_q;
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         addr_q <= 18'h00000;
         dmaw_q <= 16'h0000;
         dwr_q <= 1'b0;
         wdel_q <= 1'b0;
      end else begin
         addr_q <= {ext_q, ba_q};
         dmaw_q <= buf_q[idx_q[6:0]];
         dwr_q <= !is_fill;
         wdel_q <= (fn_q == FN_WRDEL);
      end
   end

   assign reg_rdata_out = rdata_q;
   assign irq_out = irq_q;
   assign dma_req_out = req_q;
   assign dma_write_out = dwr_q;
   assign dma_addr_out = addr_q;
   assign dma_wdata_out = dmaw_q;
   assign seek_out = seek_q;
   assign track_out = trk_q;
   assign sector_out = sec_q;
   assign unit_out = unit_q;
   assign wr_word_out = wrw_q;
   assign wr_data_out = dwd_q;
   assign wr_del_out = wdel_q;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n);

   property p_done_drop;
      start && !reg_req_in.wdata[CS_INIT] &&
      (reg_req_in.wdata[CS_FN +: 3] == FN_FILL || reg_req_in.wdata[CS_FN +: 3] == FN_EMPTY)
      |=> !done_q && tr_q;
   endproperty
   a_done_drop: assert property (p_done_drop) else $error("done not cleared");

   property p_tr_search;
      st_q == S_SRCH |-> !tr_q && !done_q;
   endproperty
   a_tr_search: assert property (p_tr_search) else $error("tr high in search");

   property p_wco;
      st_q == S_WC && db_take && reg_req_in.wdata > lim |=> es_q[ES_WCO] && err_q ##1 done_q;
   endproperty
   a_wco: assert property (p_wco) else $error("overflow not flagged");

   property p_irq;
      st_q == S_FIN && ie_q && !cs_wr |=> irq_q && done_q;
   endproperty
   a_irq: assert property (p_irq) else $error("no interrupt");

   property p_wr_clear;
      start && !reg_req_in.wdata[CS_INIT] && reg_req_in.wdata[CS_FN +: 3] == FN_WRITE
      |=> es_q == ES_RESET && !tr_q;
   endproperty
   a_wr_clear: assert property (p_wr_clear) else $error("status not cleared");

   property p_db_status;
      st_q == S_FIN && !cs_wr |=> db_q == $past(es_word);
   endproperty
   a_db_status: assert property (p_db_status) else $error("status not in data");

   property p_ba_step;
      st_q == S_DMA && dma_done && wc_q != 16'h0000 |=> ba_q == $past(ba_q) + BA_STEP;
   endproperty
   a_ba_step: assert property (p_ba_step) else $error("address not advanced");

   property p_den_err;
      st_q == S_SRCH && found_r && sel_den != den_q && !cs_wr |=> es_q[ES_DENERR] ##1 done_q;
   endproperty
   a_den_err: assert property (p_den_err) else $error("density error missed");

   property p_rd_ignore;
      st_q == S_DMA && db_rd |=> $stable(rdata_q);
   endproperty
   a_rd_ignore: assert property (p_rd_ignore) else $error("dma read not ignored");

   property p_unit;
      st_q == S_FIN && !cs_wr |=> db_q[ES_UNIT] == unit_q;
   endproperty
   a_unit: assert property (p_unit) else $error("unit bit wrong");
endmodule

// [bench/fdma_mem_model.sv]
// Behavioural host memory that answers the sequencer's DMA requests.
`timescale 1ns/1ps
module fdma_mem_model (
   // Clock.
   input  wire logic        clk_in,
   // Answer delay in cycles, so the bench can be prompt or slow.
   input  wire logic [4:0]  lat_in,
   // DMA slave side.
   input  wire logic        dma_req_in,
   input  wire logic        dma_write_in,
   input  wire logic [17:0] dma_addr_in,
   input  wire logic [15:0] dma_wdata_in,
   output logic [15:0]      dma_rdata_out,
   output logic             dma_ack_out
);
   logic [15:0] mem [0:255];
   logic [7:0]  idx;
   ////////////////////////////////////////
   // Byte addresses 0xffxx have nothing behind them and never answer.
   // Between answers the data lines carry the inverse of the last word.
   initial begin
      dma_ack_out   = 1'b0;
      dma_rdata_out = 16'h5a5a;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 16'h0000;
      end
      forever begin
         @(posedge clk_in);
         if (dma_req_in === 1'b1 && dma_addr_in[15:8] !== 8'hff) begin
            repeat (lat_in) @(posedge clk_in);
            idx = dma_addr_in[8:1];
            if (dma_write_in === 1'b1) begin
               mem[idx] = dma_wdata_in;
            end
            dma_rdata_out <= mem[idx];
            dma_ack_out   <= 1'b1;
            @(posedge clk_in);
            dma_ack_out   <= 1'b0;
            dma_rdata_out <= ~dma_rdata_out;
            @(posedge clk_in);
         end
      end
   end
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the floppy DMA function sequencer.
`timescale 1ns/1ps
module tb_top;
   import fdma_pkg::*;
   logic        clk_in, rst_n_in, irq, dma_req, dma_write, dma_ack, seek;
   logic        unit, wr_word, wr_del, found, del_mark, index, word_req, seen_u;
   reg_req_s    req;
   logic [15:0] rdata, dma_rdata, dma_wdata, wr_data, last_word;
   logic [17:0] dma_addr;
   logic [1:0]  den, rdy;
   logic [7:0]  track, sector, seen_trk, seen_sec;
   logic [4:0]  lat;
   int          fails, total_checks, words, seeks;

   fdma_seq dut_u (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
      .irq_out(irq), .dma_req_out(dma_req), .dma_write_out(dma_write),
      .dma_addr_out(dma_addr), .dma_wdata_out(dma_wdata), .dma_rdata_in(dma_rdata),
      .dma_ack_in(dma_ack), .drv_den_in(den), .drv_ready_in(rdy), .sec_found_in(found),
      .del_mark_in(del_mark), .index_in(index), .word_req_in(word_req), .seek_out(seek),
      .track_out(track), .sector_out(sector), .unit_out(unit), .wr_word_out(wr_word),
      .wr_data_out(wr_data), .wr_del_out(wr_del));

   fdma_mem_model mem_u (
      .clk_in(clk_in), .lat_in(lat), .dma_req_in(dma_req), .dma_write_in(dma_write),
      .dma_addr_in(dma_addr), .dma_wdata_in(dma_wdata), .dma_rdata_out(dma_rdata),
      .dma_ack_out(dma_ack));

   always @(posedge clk_in) begin
      if (wr_word === 1'b1) begin
         words     <= words + 1;
         last_word <= wr_data;
      end
      if (seek === 1'b1) begin
         seeks    <= seeks + 1;
         seen_u   <= unit;
         seen_trk <= track;
         seen_sec <= sector;
      end
   end
   ////////////////////////////////////////
   function automatic logic [15:0] mk_cmd(input logic [2:0] fn, input logic u, input logic d);
      return {7'h00, d, 1'b0, 1'b1, 1'b0, u, fn, 1'b1};
   endfunction

   function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 15; i >= 0; i--) begin
         r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic reg_wr(input logic sel, input logic [15:0] d);
      @(posedge clk_in);
      req <= '{sel: sel, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clk_in);
      req.wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic sel, output logic [15:0] d);
      @(posedge clk_in);
      req <= '{sel: sel, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
      @(posedge clk_in);
      req.rd <= 1'b0;
      @(posedge clk_in);
      #1 d = rdata;
   endtask

   // Polls the command register until a bit of the mask shows.
   task automatic wait_cs(input logic [15:0] m, output logic [15:0] cs);
      total_checks++;
      for (int i = 0; i < 3000; i++) begin
         reg_rd(1'b0, cs);
         if ((cs & m) !== 16'h0000) return;
      end
      fails++;
      $display("[FAIL] %0t command bits %h never rose", $time, m);
   endtask

   task automatic pulse(input int k);
      @(posedge clk_in);
      found    <= (k == 0);
      index    <= (k == 1);
      word_req <= (k == 2);
      repeat (6) @(posedge clk_in);
      found    <= 1'b0;
      index    <= 1'b0;
      word_req <= 1'b0;
      repeat (6) @(posedge clk_in);
   endtask

   // Fill or empty with unit 1 selected, which the function must not care about.
   task automatic buf_op(input logic [2:0] fn, input logic d, input logic [15:0] wc,
                         input logic [15:0] ba, input logic peek);
      logic [15:0] cs, v;
      reg_wr(1'b0, mk_cmd(fn, 1'b1, d));
      wait_cs(16'h0080, cs);
      reg_wr(1'b1, wc);
      wait_cs(16'h00a0, cs);
      if (cs[CS_TR] === 1'b1) reg_wr(1'b1, ba);
      if (peek) begin
         for (int i = 0; i < 50 && dma_req !== 1'b1; i++) @(posedge clk_in);
         reg_rd(1'b0, cs);
         reg_rd(1'b1, v);
         check(v, cs, "data read during dma");
      end
      wait_cs(16'h0020, cs);
   endtask

   task automatic wr_start(input logic [2:0] fn, input logic u, input logic d);
      logic [15:0] cs;
      int          n;
      n = seeks;
      reg_wr(1'b0, mk_cmd(fn, u, d));
      reg_rd(1'b0, cs);
      check(cs & 16'h8020, 16'h0000, "start clears done");
      wait_cs(16'h0080, cs);
      reg_wr(1'b1, 16'h0005);
      wait_cs(16'h0080, cs);
      reg_wr(1'b1, 16'h0002);
      reg_rd(1'b0, cs);
      check(cs & 16'h00a0, 16'h0000, "quiet during search");
      for (int i = 0; i < 100 && seeks == n; i++) @(posedge clk_in);
      #1 check({seen_u, seen_trk, seen_sec[6:0]}, {u, 8'h02, 7'h05}, "seek target");
   endtask
   ////////////////////////////////////////
   task automatic t_codes;
      logic [15:0] cs;
      logic [2:0]  fl [4] = '{3'h3, 3'h4, 3'h7, 3'h5};
      reg_rd(1'b0, cs);
      check(cs & 16'h0820, 16'h0820, "done after reset");
      for (int i = 0; i < 4; i++) begin
         reg_wr(1'b0, mk_cmd(fl[i], 1'b0, 1'b1));
         wait_cs(16'h0020, cs);
         check({15'h0, irq}, 16'h0001, "function ran");
      end
      reg_rd(1'b1, cs);
      check(cs & 16'h0180, 16'h0080, "drive 0 ready");
      reg_wr(1'b0, mk_cmd(FN_STATUS, 1'b1, 1'b1));
      wait_cs(16'h0020, cs);
      reg_rd(1'b1, cs);
      check(cs & 16'h0180, 16'h0100, "drive 1 not ready");
   endtask

   task automatic t_fill_empty;
      logic [15:0] v;
      mem_u.mem[8'h10] = 16'hbeef;
      mem_u.mem[8'h11] = 16'h1234;
      mem_u.mem[8'h22] = 16'hffff;
      lat <= 5'h14;
      buf_op(FN_FILL, 1'b1, 16'h0002, 16'h0020, 1'b1);
      check({15'h0, irq}, 16'h0001, "fill interrupt");
      reg_rd(1'b1, v);
      check(v & 16'h8c10, 16'h0000, "fill status word");
      lat <= 5'h00;
      buf_op(FN_EMPTY, 1'b1, 16'h0003, 16'h0040, 1'b0);
      check(mem_u.mem[8'h20], 16'hbeef, "empty word 0");
      check(mem_u.mem[8'h21], 16'h1234, "empty word 1");
      check(mem_u.mem[8'h22], 16'h0000, "zero filled word");
   endtask

   task automatic t_wr_ok;
      logic [15:0] cs, exp;
      int          n;
      exp = crc_word(crc_word(CRC_INIT, 16'hbeef), 16'h1234);
      for (int i = 0; i < 126; i++) exp = crc_word(exp, 16'h0000);
      n = words;
      wr_start(FN_WRITE, 1'b0, 1'b1);
      check({15'h0, wr_del}, 16'h0000, "plain data mark");
      @(posedge clk_in) del_mark <= 1'b1;
      pulse(0);
      del_mark <= 1'b0;
      for (int i = 0; i < 129; i++) pulse(2);
      wait_cs(16'h0020, cs);
      check(cs & 16'h8040, 16'h0040, "write ends clean");
      check(16'(words - n), 16'h0081, "words plus crc");
      check(last_word, exp, "crc word");
      reg_rd(1'b1, cs);
      check(cs & 16'h0170, 16'h0060, "density and deleted mark");
   endtask

   task automatic t_wr_fail;
      logic [15:0] cs;
      int          n;
      n = words;
      wr_start(FN_WRDEL, 1'b1, 1'b1);
      check({15'h0, wr_del}, 16'h0001, "deleted mark mode");
      pulse(0);
      wait_cs(16'h0020, cs);
      check(cs & 16'h8000, 16'h8000, "density abort");
      check(16'(words - n), 16'h0000, "nothing written");
      reg_rd(1'b1, cs);
      check(cs & 16'h0110, 16'h0110, "density error on unit 1");
      wr_start(FN_WRITE, 1'b0, 1'b1);
      pulse(1);
      pulse(1);
      wait_cs(16'h0020, cs);
      check(cs & 16'h8000, 16'h8000, "sector not found");
      reg_rd(1'b1, cs);
      check(cs & 16'h0010, 16'h0000, "old status cleared");
   endtask

   task automatic t_limits;
      logic [15:0] cs;
      buf_op(FN_FILL, 1'b0, 16'h0041, 16'h0020, 1'b0);
      reg_rd(1'b0, cs);
      check(cs & 16'h8020, 16'h8020, "overflow ends fill");
      reg_rd(1'b1, cs);
      check(cs & 16'h0400, 16'h0400, "overflow flag");
      buf_op(FN_EMPTY, 1'b0, 16'h0040, 16'h0100, 1'b0);
      reg_rd(1'b0, cs);
      check(cs & 16'h8000, 16'h0000, "single limit accepted");
      buf_op(FN_FILL, 1'b1, 16'h0001, 16'hff00, 1'b0);
      reg_rd(1'b0, cs);
      check(cs & 16'h8020, 16'h8020, "missing memory error");
      reg_rd(1'b1, cs);
      check(cs & 16'h0800, 16'h0800, "missing memory flag");
   endtask

   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // The whole run needs well under 1 ms; five leaves ample margin.
   initial begin
      #5000000;
      fails++;
      $display("[FAIL] %0t run timed out", $time);
      end_of_test();
   end

   initial begin
      rst_n_in = 1'b0;
      req = '0;
      {found, del_mark, index, word_req} = 4'h0;
      den = 2'b01;
      rdy = 2'b01;
      lat = 5'h00;
      fails = 0;
      total_checks = 0;
      words = 0;
      seeks = 0;
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      t_codes();
      t_fill_empty();
      t_wr_ok();
      t_wr_fail();
      t_limits();
      end_of_test();
   end
endmodule
